// [core/srfdr_top.sv]
// Design decision made here: the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - Done flag read and clear only
// - Done flag set at frame end when enabled
// - Frame length field 1 to 15 bits
// - Usual frame length is eight bits
// - Extra leading bits fall off the top
// - Divide field sets master bit clock
// - Codes give 1..64 and 256 ratios
// - Capture on edge chosen by polarity/phase
// - Most significant bit shifted first
// - Data read returns shift register
// - Misc bit0 routes shift output pin
// - Misc register write only, reserved bits
// - All four polarity and phase modes
// - Run flag cleared at end or abort
// - Phase sets when top bit appears
// - Clock source picks master or slave
// - Input select gates data-in pin
module srfdr_top
	import srfdr_pkg::*;
#(
	parameter int ADDR_W = 10,
	parameter int CORE_DIV = CORE_DIV_DEF
) (
	// Clock and reset
	input wire logic CLK_SYS,
	input wire logic SRST,
	// Avalon-MM slave
	input wire logic [ADDR_W-1:0] AVS_ADDRESS,
	input wire logic AVS_READ,
	input wire logic AVS_WRITE,
	input wire logic [31:0] AVS_WRITEDATA,
	input wire logic [3:0] AVS_BYTEENABLE,
	output logic [31:0] AVS_READDATA,
	output logic AVS_WAITREQUEST,
	// Serial clock pin
	input wire logic SCK_IN,
	output logic SCK_OUT,
	output logic SCK_OE,
	// Serial data pins
	input wire logic SIN,
	output logic SOUT,
	output logic SOUT_OE,
	// Request towards the interrupt unit
	output logic IRQ_REQ
);
	srfdr_rate_if rif ();

	srfdr_state_t state_reg; // Transfer sequencer
	logic [7:0] shreg_reg; // Data and shift register
	logic [FLEN_W-1:0] flen_reg; // Frame length field
	logic [CDIV_W-1:0] cdiv_reg; // Clock divide field
	logic done_reg; // Transfer done flag
	logic [7:0] mode_reg; // Mode control register
	logic [7:0] misc_reg; // Output select register
	logic [FLEN_W-1:0] bitcnt_reg; // Bits left in frame
	logic sample_reg; // Bit caught on leading edge
	logic sck_prev_reg; // Last filtered clock level
	logic sin_prev_reg; // Last filtered data-in level
	logic wait_reg; // Bus wait state
	logic sck_f; // Filtered clock pin
	logic sin_f; // Filtered data-in pin
	logic [7:0] idx; // Register index of the access
	logic hit_data; // Access to data register
	logic hit_rate; // Access to rate register
	logic hit_mode; // Access to mode register
	logic hit_misc; // Access to misc register
	logic wr_go; // Write taken this edge
	logic run; // Running flag
	logic clock_polarity; // Clock polarity
	logic clock_phase; // Clock phase
	logic master; // Clock sourced here
	logic sin_bit; // Serial input after gating
	logic shift_bit; // Bit entering the shift register
	logic lead_evt; // Leading clock edge
	logic trail_evt; // Trailing clock edge
	logic start_evt; // Frame starts
	logic end_evt; // Last bit shifted
	logic abort_evt; // Software stopped a transfer
	logic busy; // Transfer active or armed
	logic [7:0] rd_byte; // Selected read value

	// Input noise filters, enabled while the disable bit is clear
	srfdr_pin_filter u_sck_filt (
		.clk(CLK_SYS),
		.srst(SRST),
		.filt_en(!mode_reg[MODE_FDIS_BIT]),
		.pin(SCK_IN),
		.level(sck_f)
	);

	srfdr_pin_filter u_sin_filt (
		.clk(CLK_SYS),
		.srst(SRST),
		.filt_en(!mode_reg[MODE_FDIS_BIT]),
		.pin(SIN),
		.level(sin_f)
	);

	// Master bit clock generator
	srfdr_rate_gen #(
		.CORE_DIV(CORE_DIV)
	) u_rate (
		.clk(CLK_SYS),
		.srst(SRST),
		.rif(rif)
	);

	// Mode fields
	assign run = mode_reg[MODE_RUN_BIT];
	assign clock_polarity = mode_reg[MODE_CLOCK_POLARITY_BIT];
	assign clock_phase = mode_reg[MODE_CLOCK_PHASE_BIT];
	assign master = mode_reg[MODE_CLKSRC_BIT];
	assign busy = (state_reg != ST_IDLE) || run;

	// Bus decode; only the low byte lane carries data
	assign idx = AVS_ADDRESS[9:2];
	assign hit_data = (idx == IDX_DATA);
	assign hit_rate = (idx == IDX_RATE);
	assign hit_mode = (idx == IDX_MODE);
	assign hit_misc = (idx == IDX_MISC);
	assign wr_go = AVS_WRITE && !wait_reg && AVS_BYTEENABLE[0];

	// Divider runs only during a master frame
	assign rif.run = (state_reg == ST_SHIFT) && master;
	assign rif.code = cdiv_reg;

	// Serial input held low unless selected
	assign sin_bit = mode_reg[MODE_INSEL_BIT] ? sin_f : 1'b0;

	// Phase one captures on the trailing edge, phase zero on the leading edge
	assign shift_bit = clock_phase ? sin_bit : sample_reg;

	// Edge events come from the divider as master or from the pin as slave
	always_comb begin
		lead_evt = 1'b0;
		trail_evt = 1'b0;
		if (state_reg == ST_SHIFT) begin
			if (master) begin
				lead_evt = rif.lead;
				trail_evt = rif.trail;
			end else begin
				// Leading edge leaves the idle level, trailing returns to it
				lead_evt = (sck_prev_reg == clock_polarity) && (sck_f != clock_polarity);
				trail_evt = (sck_prev_reg != clock_polarity) && (sck_f == clock_polarity);
			end
		end
	end

	// Frame control events
	assign end_evt = trail_evt && (bitcnt_reg == 4'h1);
	assign abort_evt = (state_reg != ST_IDLE) && !run;
	always_comb begin
		start_evt = 1'b0;
		if (run) begin
			if ((state_reg == ST_IDLE) && !mode_reg[MODE_STSEL_BIT]) begin
				start_evt = 1'b1;
			end else if ((state_reg == ST_ARM) && sin_f && !sin_prev_reg) begin
				// External start needs a rising data-in edge
				start_evt = 1'b1;
			end
		end
	end

	// Transfer sequencer
	always_ff @(posedge CLK_SYS) begin
		if (SRST) begin
			state_reg <= ST_IDLE;
		end else begin
			case (state_reg)
				ST_IDLE: begin
					if (start_evt) begin
						state_reg <= ST_SHIFT;
					end else if (run) begin
						state_reg <= ST_ARM;
					end
				end
				ST_ARM: begin
					if (!run) begin
						state_reg <= ST_IDLE;
					end else if (start_evt) begin
						state_reg <= ST_SHIFT;
					end
				end
				ST_SHIFT: begin
					if (end_evt || !run) begin
						state_reg <= ST_IDLE;
					end
				end
				default: begin
					state_reg <= ST_IDLE;
				end
			endcase
		end
	end

	// Bit counter loads the frame length and counts shifted bits
	always_ff @(posedge CLK_SYS) begin
		if (SRST) begin
			bitcnt_reg <= 4'h0;
		end else if (start_evt) begin
			bitcnt_reg <= flen_reg;
		end else if (trail_evt) begin
			bitcnt_reg <= bitcnt_reg - 4'h1;
		end
	end

	// Shift register: bits beyond eight push the oldest ones out of the top
	always_ff @(posedge CLK_SYS) begin
		if (SRST) begin
			shreg_reg <= DATA_RST;
		end else if (trail_evt) begin
			shreg_reg <= {shreg_reg[6:0], shift_bit};
		end else if (wr_go && hit_data && !busy) begin
			shreg_reg <= AVS_WRITEDATA[7:0];
		end
	end

	// Leading edge sample for phase zero
	always_ff @(posedge CLK_SYS) begin
		if (SRST) begin
			sample_reg <= 1'b0;
		end else if (lead_evt) begin
			sample_reg <= sin_bit;
		end
	end

	// Previous pin levels for edge detection
	always_ff @(posedge CLK_SYS) begin
		if (SRST) begin
			sck_prev_reg <= 1'b0;
			sin_prev_reg <= 1'b0;
		end else begin
			sck_prev_reg <= sck_f;
			sin_prev_reg <= sin_f;
		end
	end

	// Rate fields are frozen while a transfer is running
	always_ff @(posedge CLK_SYS) begin
		if (SRST) begin
			{flen_reg, cdiv_reg} <= RATE_RST;
		end else if (wr_go && hit_rate && !busy) begin
			flen_reg <= AVS_WRITEDATA[FLEN_LSB +: FLEN_W];
			cdiv_reg <= AVS_WRITEDATA[CDIV_LSB +: CDIV_W];
		end
	end

	// Done flag: set by hardware only, a written zero clears, set wins
	always_ff @(posedge CLK_SYS) begin
		if (SRST) begin
			done_reg <= 1'b0;
		end else if ((end_evt || abort_evt) && mode_reg[MODE_IRQEN_BIT]) begin
			done_reg <= 1'b1;
		end else if (wr_go && hit_rate && !AVS_WRITEDATA[RATE_FLAG_BIT]) begin
			done_reg <= 1'b0;
		end
	end

	// Mode register; a software write wins over the end-of-frame run clear
	always_ff @(posedge CLK_SYS) begin
		if (SRST) begin
			mode_reg <= MODE_RST;
		end else if (wr_go && hit_mode) begin
			mode_reg <= AVS_WRITEDATA[7:0];
		end else if (end_evt) begin
			mode_reg[MODE_RUN_BIT] <= 1'b0;
		end
	end

	// Miscellaneous register, only bit 0 is kept
	always_ff @(posedge CLK_SYS) begin
		if (SRST) begin
			misc_reg <= MISC_RST;
		end else if (wr_go && hit_misc) begin
			misc_reg <= {7'h00, AVS_WRITEDATA[MISC_SOUT_BIT]};
		end
	end

	// Serial data out: phase zero follows the top bit, phase one moves on leading edges
	always_ff @(posedge CLK_SYS) begin
		if (SRST) begin
			SOUT <= 1'b0;
		end else if (!clock_phase) begin
			SOUT <= shreg_reg[7];
		end else if (lead_evt) begin
			SOUT <= shreg_reg[7];
		end
	end

	// Pin enables from the select bits
	always_ff @(posedge CLK_SYS) begin
		if (SRST) begin
			SOUT_OE <= 1'b0;
			SCK_OE <= 1'b0;
		end else begin
			SOUT_OE <= misc_reg[MISC_SOUT_BIT];
			SCK_OE <= master;
		end
	end

	// Master clock toggles on divider ticks and rests at the polarity level
	always_ff @(posedge CLK_SYS) begin
		if (SRST) begin
			SCK_OUT <= 1'b0;
		end else if (!rif.run || end_evt) begin
			SCK_OUT <= clock_polarity;
		end else if (rif.lead) begin
			SCK_OUT <= !clock_polarity;
		end else if (rif.trail) begin
			SCK_OUT <= clock_polarity;
		end
	end

	// Interrupt request level
	always_ff @(posedge CLK_SYS) begin
		if (SRST) begin
			IRQ_REQ <= 1'b0;
		end else begin
			IRQ_REQ <= done_reg && mode_reg[MODE_IRQEN_BIT];
		end
	end

	// Read value; misc and unmapped addresses read zero
	always_comb begin
		rd_byte = 8'h00;
		if (hit_data) begin
			rd_byte = shreg_reg;
		end else if (hit_rate) begin
			rd_byte = {done_reg, flen_reg, cdiv_reg};
		end else if (hit_mode) begin
			rd_byte = mode_reg;
		end
	end

	// One wait cycle per access, then completion
	always_ff @(posedge CLK_SYS) begin
		if (SRST) begin
			AVS_WAITREQUEST <= 1'b1;
			wait_reg <= 1'b1;
		end else if ((AVS_READ || AVS_WRITE) && wait_reg) begin
			AVS_WAITREQUEST <= 1'b0;
			wait_reg <= 1'b0;
		end else begin
			AVS_WAITREQUEST <= 1'b1;
			wait_reg <= 1'b1;
		end
	end

	// Read data captured in the wait cycle
	always_ff @(posedge CLK_SYS) begin
		if (SRST) begin
			AVS_READDATA <= 32'h00000000;
		end else if (AVS_READ && wait_reg) begin
			AVS_READDATA <= {24'h000000, rd_byte};
		end
	end

	default clocking cb @(posedge CLK_SYS);
	endclocking
	default disable iff (SRST);

	sequence s_frame_end;
		end_evt ##1 !run;
	endsequence
	sequence s_rd_misc;
		AVS_READ && !AVS_WAITREQUEST && hit_misc;
	endsequence

	property p_flag_cause;
		$rose(done_reg) |-> $past(end_evt || abort_evt);
	endproperty
	a_flag_cause: assert property (p_flag_cause) else $error("done flag set by software");
	property p_flag_set;
		(end_evt && mode_reg[MODE_IRQEN_BIT]) |=> done_reg ##1 IRQ_REQ;
	endproperty
	a_flag_set: assert property (p_flag_set) else $error("done flag missed");
	property p_len_load;
		start_evt |=> (bitcnt_reg == $past(flen_reg)) && (state_reg == ST_SHIFT);
	endproperty
	a_len_load: assert property (p_len_load) else $error("bit counter not loaded");
	property p_run_clear;
		(end_evt && !wr_go) |-> s_frame_end ##0 (state_reg == ST_IDLE);
	endproperty
	a_run_clear: assert property (p_run_clear) else $error("run flag not cleared");
	property p_msb_first;
		trail_evt |=> (shreg_reg[7:1] == $past(shreg_reg[6:0]));
	endproperty
	a_msb_first: assert property (p_msb_first) else $error("shift direction wrong");
	property p_in_gate;
		(trail_evt && !mode_reg[MODE_INSEL_BIT]) |=> !shreg_reg[0];
	endproperty
	a_in_gate: assert property (p_in_gate) else $error("gated input not zero");
	property p_cpha0_out;
		!clock_phase && $stable(clock_phase) |-> ##1 (SOUT == $past(shreg_reg[7]));
	endproperty
	a_cpha0_out: assert property (p_cpha0_out) else $error("phase zero output late");
	property p_idle_clk;
		(!rif.run && $stable(clock_polarity)) [*2] |-> (SCK_OUT == clock_polarity);
	endproperty
	a_idle_clk: assert property (p_idle_clk) else $error("clock not idle");
	property p_misc_zero;
		s_rd_misc |-> (AVS_READDATA == 32'h00000000);
	endproperty
	a_misc_zero: assert property (p_misc_zero) else $error("misc read not zero");
	property p_sout_sel;
		$changed(misc_reg[MISC_SOUT_BIT]) |=> (SOUT_OE == $past(misc_reg[MISC_SOUT_BIT]));
	endproperty
	a_sout_sel: assert property (p_sout_sel) else $error("output select wrong");
endmodule : srfdr_top
`default_nettype wire

// [inc/srfdr_pkg.sv]
package srfdr_pkg;
	// Register indexes; the byte address is four times the index
	localparam logic [7:0] IDX_DATA = 8'hE0;
	localparam logic [7:0] IDX_RATE = 8'hE1;
	localparam logic [7:0] IDX_MODE = 8'hE2;
	localparam logic [7:0] IDX_MISC = 8'hDD;
	// Rate register fields
	localparam int RATE_FLAG_BIT = 7;
	localparam int FLEN_LSB = 3;
	localparam int FLEN_W = 4;
	localparam int CDIV_LSB = 0;
	localparam int CDIV_W = 3;
	// Mode register fields
	localparam int MODE_RUN_BIT = 7;
	localparam int MODE_IRQEN_BIT = 6;
	localparam int MODE_CLOCK_PHASE_BIT = 5;
	localparam int MODE_CLKSRC_BIT = 4;
	localparam int MODE_INSEL_BIT = 3;
	localparam int MODE_STSEL_BIT = 2;
	localparam int MODE_FDIS_BIT = 1;
	localparam int MODE_CLOCK_POLARITY_BIT = 0;
	// Output select bit of the miscellaneous register
	localparam int MISC_SOUT_BIT = 0;
	// Reset values
	localparam logic [7:0] DATA_RST = 8'h00;
	localparam logic [6:0] RATE_RST = 7'h00;
	localparam logic [7:0] MODE_RST = 8'h00;
	localparam logic [7:0] MISC_RST = 8'h00;
	// System clocks per core cycle
	localparam int CORE_DIV_DEF = 13;
	// Transfer sequencer states
	typedef enum logic [1:0] {ST_IDLE, ST_ARM, ST_SHIFT} srfdr_state_t;
	// Bit clock ratio for a divide code
	function automatic logic [8:0] srfdr_ratio(input logic [2:0] code);
		if (code == 3'h7) begin
			return 9'h100;
		end
		return 9'(9'h001 << code);
	endfunction : srfdr_ratio
endpackage : srfdr_pkg

// [inc/srfdr_rate_if.sv]
`timescale 1ns/1ps
`default_nettype none
interface srfdr_rate_if;
	logic run; // Divider runs while high
	logic [2:0] code; // Divide code
	logic lead; // Leading shift clock edge due
	logic trail; // Trailing shift clock edge due
	modport gen (input run, input code, output lead, output trail);
	modport use_side (output run, output code, input lead, input trail);
endinterface : srfdr_rate_if
`default_nettype wire

// [core/srfdr_pin_filter.sv]
`timescale 1ns/1ps
`default_nettype none
module srfdr_pin_filter (
	// Clock and reset
	input wire logic clk,
	input wire logic srst,
	// Filter control and pin
	input wire logic filt_en,
	input wire logic pin,
	// Cleaned level
	output logic level
);
	logic last_reg; // Previous pin sample

	// Remember the last sample
	always_ff @(posedge clk) begin
		if (srst) begin
			last_reg <= 1'b0;
		end else begin
			last_reg <= pin;
		end
	end

	// Accept a new level only after two equal samples, or at once when bypassed
	always_ff @(posedge clk) begin
		if (srst) begin
			level <= 1'b0;
		end else if (!filt_en || (pin == last_reg)) begin
			level <= pin;
		end
	end
endmodule : srfdr_pin_filter
`default_nettype wire

// [core/srfdr_rate_gen.sv]
`timescale 1ns/1ps
`default_nettype none
module srfdr_rate_gen
	import srfdr_pkg::*;
#(
	parameter int CORE_DIV = CORE_DIV_DEF
) (
	// Clock and reset
	input wire logic clk,
	input wire logic srst,
	// Divider control and edge ticks
	srfdr_rate_if.gen rif
);
	logic [11:0] period; // System clocks per bit
	logic [11:0] cnt_reg; // Position inside the bit
	logic [11:0] gap_reg; // Clocks since last leading tick
	logic seen_reg; // A leading tick has occurred

	// Core cycle times the selected ratio
	assign period = 12'(CORE_DIV * srfdr_ratio(rif.code));
	assign rif.lead = rif.run && (cnt_reg == 12'h000);
	assign rif.trail = rif.run && (cnt_reg == (period >> 1));

	// Bit position counter, held at zero while stopped
	always_ff @(posedge clk) begin
		if (srst || !rif.run) begin
			cnt_reg <= 12'h000;
		end else if (cnt_reg == period - 12'h001) begin
			cnt_reg <= 12'h000;
		end else begin
			cnt_reg <= cnt_reg + 12'h001;
		end
	end

	// Spacing monitor for the check below
	always_ff @(posedge clk) begin
		if (srst || !rif.run) begin
			gap_reg <= 12'h000;
			seen_reg <= 1'b0;
		end else if (rif.lead) begin
			gap_reg <= 12'h000;
			seen_reg <= 1'b1;
		end else begin
			gap_reg <= gap_reg + 12'h001;
		end
	end

	property p_bit_period;
		@(posedge clk) disable iff (srst)
		(rif.lead && seen_reg) |-> (gap_reg == period - 12'h001);
	endproperty
	a_bit_period: assert property (p_bit_period) else $error("bit period wrong");
endmodule : srfdr_rate_gen
`default_nettype wire

// [bench/srfdr_peer.sv]
`timescale 1ns/1ps
`default_nettype none
// Far-side serial device: slave on the device clock, or master driving its own clock
module srfdr_peer (
	// Clock
	input wire logic clk,
	// Mode agreed with the device
	input wire logic clock_polarity,
	input wire logic clock_phase,
	// Pin levels
	input wire logic line,
	input wire logic sout,
	output logic sin,
	output logic sck,
	output logic drv
);
	logic [15:0] tx; // Bits still to send, top first
	logic [15:0] rx; // Bits taken from the device
	logic [4:0] len; // Frame length
	logic [4:0] cnt; // Trailing edges seen
	logic dbit; // Data bit on the wire
	logic junk; // Filler while not in a frame
	logic armed; // Frame in progress
	logic prev; // Clock level one cycle ago
	initial begin
		{tx, rx, len, cnt, dbit, junk, armed, prev, sck, drv} = '0;
	end
	// A released data line never keeps its last value
	assign sin = armed ? dbit : junk;
	// Follow clock edges on the wire, move one bit each way per period
	always @(posedge clk) begin
		prev <= line;
		junk <= ~junk;
		if (armed && line != prev) begin
			// Shift on leading edge with phase one, on trailing with phase zero
			if ((line != clock_polarity) == clock_phase) begin
				dbit <= tx[15];
				tx <= {tx[14:0], 1'h0};
			end else begin
				rx <= {rx[14:0], sout};
			end
			// Trailing edge closes one bit
			if (line == clock_polarity) begin
				cnt <= cnt + 5'h01;
				if (cnt + 5'h01 == len) begin
					armed <= 1'h0;
				end
			end
		end
	end
	// Prepare a frame; the wire is left to settle before edges count
	task load(input logic [15:0] v, input logic [4:0] n, input logic slv);
		tx <= clock_phase ? v : {v[14:0], 1'h0};
		dbit <= v[15];
		rx <= 16'h0000;
		len <= n;
		cnt <= 5'h00;
		drv <= slv;
		sck <= clock_polarity;
		repeat (4) @(posedge clk);
		armed <= 1'h1;
	endtask : load
	// Act as master: slow clock so the device input filter keeps up
	task clock_frame(input int n);
		repeat (n) begin
			repeat (20) @(posedge clk);
			sck <= ~clock_polarity;
			repeat (20) @(posedge clk);
			sck <= clock_polarity;
		end
		repeat (20) @(posedge clk);
		drv <= 1'h0;
	endtask : clock_frame
endmodule : srfdr_peer
`default_nettype wire

// [bench/tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	import srfdr_pkg::*;
	localparam int CDIV = 2; // Short core cycle keeps runs brief
	// Design side signals
	logic CLK_SYS = 1'h0;
	logic SRST = 1'h1;
	logic [9:0] addr = 10'h000;
	logic rrq = 1'h0;
	logic wrq = 1'h0;
	logic [31:0] wdat = 32'h00000000;
	logic [31:0] rdat;
	logic wreq;
	logic sck_out, sck_oe, sout, sout_oe, irq;
	// Wire levels and far side
	logic pol = 1'h0;
	logic pha = 1'h0;
	logic tog = 1'h0;
	logic p_sin, p_sck, p_drv, sck_w, sout_w;
	int failures = 0;
	int checked = 0;
	int hi_cnt = 0; // Cycles the master clock sat away from its idle level
	assign sck_w = sck_oe ? sck_out : (p_drv ? p_sck : tog);
	assign sout_w = sout_oe ? sout : tog;
	always #5 CLK_SYS = ~CLK_SYS;
	// Filler pattern and clock activity count
	always @(posedge CLK_SYS) begin
		tog <= ~tog;
		if (sck_out !== pol) begin
			hi_cnt <= hi_cnt + 1;
		end
	end
	srfdr_top #(.CORE_DIV(CDIV)) dut (.CLK_SYS(CLK_SYS), .SRST(SRST), .AVS_ADDRESS(addr),
		.AVS_READ(rrq), .AVS_WRITE(wrq), .AVS_WRITEDATA(wdat), .AVS_BYTEENABLE(4'hF),
		.AVS_READDATA(rdat), .AVS_WAITREQUEST(wreq), .SCK_IN(sck_w), .SCK_OUT(sck_out),
		.SCK_OE(sck_oe), .SIN(p_sin), .SOUT(sout), .SOUT_OE(sout_oe), .IRQ_REQ(irq));
	srfdr_peer peer (.clk(CLK_SYS), .clock_polarity(pol), .clock_phase(pha), .line(sck_w), .sout(sout_w),
		.sin(p_sin), .sck(p_sck), .drv(p_drv));
	// Verdict and end of run
	task report_and_stop;
		if (failures == 0 && checked > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : report_and_stop
	// Compare and count
	task chk(input logic [15:0] got, input logic [15:0] exp);
		checked++;
		if (got !== exp) begin
			failures++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	// One register access, held until waitrequest is seen low
	task bus(input logic w, input logic [7:0] idx, input logic [7:0] wd, output logic [7:0] rd);
		int k;
		k = 0;
		addr <= {idx, 2'h0};
		wrq <= w;
		rrq <= ~w;
		wdat <= {24'h000000, wd};
		do begin
			@(posedge CLK_SYS);
			k++;
		end while (wreq !== 1'h0 && k < 50);
		rd = rdat[7:0];
		wrq <= 1'h0;
		rrq <= 1'h0;
		if (k == 50) begin
			failures++;
			report_and_stop;
		end
		@(posedge CLK_SYS);
	endtask : bus
	// Poll the run bit under a bound
	task wait_done;
		int k;
		logic [7:0] r;
		k = 0;
		do begin
			bus(1'h0, IDX_MODE, 8'h00, r);
			k++;
		end while (r[MODE_RUN_BIT] !== 1'h0 && k < 3000);
		if (k == 3000) begin
			failures++;
			report_and_stop;
		end
	endtask : wait_done
	// Bit clock ratio of a divide code
	function automatic int ratio(input logic [2:0] c);
		return (c == 3'h7) ? 256 : (1 << c);
	endfunction : ratio
	// Bits sent (upper byte) and final shift register (lower byte) of a frame
	function automatic logic [15:0] expect_bits(input logic [7:0] d, input logic [15:0] v,
		input int n, input logic ins);
		logic [7:0] s;
		logic [7:0] r;
		s = d;
		r = 8'h00;
		for (int i = n - 1; i >= 0; i--) begin
			r = {r[6:0], s[7]};
			s = {s[6:0], ins & v[i]};
		end
		return {r, s};
	endfunction : expect_bits
	// Full frame: set up, run, check data both ways, flag, request and clock rate
	task xfer(input logic ms, ins, ie, fd, p, h, input logic [3:0] n, input logic [2:0] c,
		input logic [7:0] d, input logic [15:0] v);
		logic [7:0] r;
		logic [7:0] md;
		logic [15:0] e;
		int h0;
		md = {1'h0, ie, h, ms, ins, 1'h0, fd, p};
		e = expect_bits(d, v, n, ins);
		pol <= p;
		pha <= h;
		bus(1'h1, IDX_MISC, 8'h01, r);
		bus(1'h1, IDX_RATE, {1'h0, n, c}, r);
		bus(1'h1, IDX_DATA, d, r);
		bus(1'h1, IDX_MODE, md, r);
		@(negedge CLK_SYS);
		chk(sck_oe, ms);
		chk(sout_oe, 1'h1);
		if (!h) chk(sout, d[7]);
		@(posedge CLK_SYS);
		peer.load(v << (16 - n), {1'h0, n}, ~ms);
		h0 = hi_cnt;
		bus(1'h1, IDX_MODE, md | 8'h80, r);
		if (!ms) peer.clock_frame(n);
		wait_done;
		chk(16'(hi_cnt - h0), ms ? 16'(n * ((CDIV * ratio(c)) / 2)) : 16'h0000);
		bus(1'h0, IDX_DATA, 8'h00, r);
		chk(r, e[7:0]);
		chk(peer.rx[7:0], e[15:8]);
		bus(1'h0, IDX_RATE, 8'h00, r);
		chk(r, {ie, n, c});
		chk(irq, ie);
		bus(1'h1, IDX_RATE, {1'h0, n, c}, r);
		bus(1'h0, IDX_RATE, 8'h00, r);
		chk(r, {1'h0, n, c});
		chk(irq, 1'h0);
	endtask : xfer
	// Main sequence
	initial begin
		logic [7:0] r;
		int h0;
		void'($urandom(49981));
		repeat (6) @(posedge CLK_SYS);
		SRST <= 1'h0;
		@(posedge CLK_SYS);
		// Reset values, reserved and unmapped places
		bus(1'h0, IDX_RATE, 8'h00, r);
		chk(r, 8'h00);
		bus(1'h0, IDX_DATA, 8'h00, r);
		chk(r, DATA_RST);
		bus(1'h1, IDX_MISC, 8'hFE, r);
		bus(1'h0, IDX_MISC, 8'h00, r);
		chk(r, 8'h00);
		chk(sout_oe, 1'h0);
		bus(1'h1, 8'h10, 8'h5A, r);
		bus(1'h0, 8'h10, 8'h00, r);
		chk(r, 8'h00);
		bus(1'h1, IDX_RATE, 8'hFF, r);
		bus(1'h0, IDX_RATE, 8'h00, r);
		chk(r, 8'h7F);
		// Every divide code with one-bit frames
		for (int c = 0; c < 8; c++) begin
			xfer(1'h1, 1'h1, 1'h1, 1'h0, c[0], 1'h0, 4'h1, c[2:0], 8'($urandom), 16'($urandom));
		end
		// Long frame drops leading bits; input select off gives zeros
		xfer(1'h1, 1'h1, 1'h1, 1'h0, 1'h0, 1'h1, 4'hA, 3'h3, 8'hC3, 16'h02A5);
		xfer(1'h1, 1'h0, 1'h1, 1'h1, 1'h1, 1'h0, 4'h8, 3'h2, 8'hFF, 16'hFFFF);
		xfer(1'h1, 1'h1, 1'h0, 1'h0, 1'h1, 1'h1, 4'hF, 3'h3, 8'h81, 16'h7E5A);
		// Random mix of master and slave, all polarity and phase modes
		repeat (14) begin
			xfer(1'($urandom), 1'($urandom), 1'($urandom), 1'($urandom), 1'($urandom),
				1'($urandom), 4'(1 + $urandom % 15), 3'(2 + $urandom % 2), 8'($urandom),
				16'($urandom));
		end
		// External start: the armed frame waits for a rising data-in edge
		pol <= 1'h0;
		pha <= 1'h0;
		bus(1'h1, IDX_RATE, 8'h42, r);
		bus(1'h1, IDX_DATA, 8'h96, r);
		bus(1'h1, IDX_MODE, 8'h54, r);
		peer.load(16'h0000, 5'h08, 1'h0);
		h0 = hi_cnt;
		bus(1'h1, IDX_MODE, 8'hD4, r);
		repeat (20) @(posedge CLK_SYS);
		chk(16'(hi_cnt - h0), 16'h0000);
		peer.load(16'hFF00, 5'h08, 1'h0);
		wait_done;
		chk(16'(hi_cnt - h0), 16'(8 * ((CDIV * ratio(3'h2)) / 2)));
		chk(peer.rx[7:0], 8'h96);
		bus(1'h0, IDX_DATA, 8'h00, r);
		chk(r, 8'h00);
		bus(1'h0, IDX_RATE, 8'h00, r);
		chk(r, 8'hC2);
		chk(irq, 1'h1);
		// Software stop in mid-frame
		bus(1'h1, IDX_RATE, 8'h7F, r);
		bus(1'h1, IDX_MODE, {7'h68, pol}, r);
		repeat (300) @(posedge CLK_SYS);
		bus(1'h1, IDX_MODE, {7'h28, pol}, r);
		bus(1'h0, IDX_MODE, 8'h00, r);
		chk(r, {7'h28, pol});
		bus(1'h0, IDX_RATE, 8'h00, r);
		chk(r, 8'hFF);
		report_and_stop;
	end
endmodule : tb_top
`default_nettype wire
